// *** design/cdcs_pkg.sv ***
package cdcs_pkg;

	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [3:0] ADDR_CHARGE  = 4'h0;
	localparam logic [3:0] ADDR_DISCH   = 4'h1;
	localparam logic [3:0] ADDR_SEQ     = 4'h2;
	localparam logic [3:0] ADDR_CONV    = 4'h3;
	localparam logic [3:0] ADDR_CONVTM  = 4'h4;
	localparam logic [3:0] ADDR_CMD     = 4'h5;
	localparam logic [3:0] ADDR_STATUS  = 4'h6;
	localparam logic [3:0] ADDR_COUNT   = 4'h7;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int POS_FULL      = 16;
	localparam int POS_PORTEN    = 0;
	localparam int POS_REFINT    = 8;
	localparam int POS_DIFF      = 9;
	localparam int POS_FLOAT     = 10;
	localparam int POS_COMPINT   = 11;
	localparam int POS_COMPEXT   = 12;
	localparam int POS_BALANCE   = 13;
	localparam int POS_FASTOSC   = 14;
	localparam int POS_AVRG      = 0;
	localparam int POS_FAKE      = 16;
	localparam int POS_TRIG      = 20;
	localparam int POS_PINSEL    = 24;

	// ********************************************************************
	// Codes and reset values
	// ********************************************************************
	localparam logic [9:0]  PHASE_SKIP     = 10'h3FF;
	localparam logic [9:0]  RST_PHASE      = 10'h000;
	localparam logic [5:0]  RST_PORTEN     = 6'h00;
	localparam logic [12:0] RST_AVRG       = 13'h0000;
	localparam logic [3:0]  RST_FAKE       = 4'h0;
	localparam logic [2:0]  RST_TRIG       = 3'h6;
	localparam logic [23:0] RST_CONVTM     = 24'h000000;
	localparam logic [2:0]  TRIG_CONT      = 3'h0;
	localparam logic [2:0]  TRIG_READ      = 3'h1;
	localparam logic [2:0]  TRIG_TIMER     = 3'h2;
	localparam logic [2:0]  TRIG_STRETCH   = 3'h3;
	localparam logic [2:0]  TRIG_PIN       = 3'h5;
	localparam logic [2:0]  TRIG_CMD       = 3'h6;
	localparam logic [2:0]  TRIG_CONTEXP   = 3'h7;
	localparam int          PORT_COUNT     = 6;
	localparam int          PIN_COUNT      = 4;

	typedef struct packed {
		logic [9:0]  preCharge;
		logic [9:0]  fullCharge;
		logic [9:0]  discharge;
		logic        fastOscillator;
	} cdcs_timing_t;

	typedef struct packed {
		logic [5:0]  portEnable;
		logic        refInternal;
		logic        differential;
		logic        floating;
		logic        compInternal;
		logic        parasiticCompEnable;
		logic        dcFreePortDrive;
	} cdcs_seq_t;

	// Port drive codes toward the analog front end.
	typedef struct packed {
		logic [6:0]  charge;
		logic [6:0]  highZ;
		logic [6:0]  sense;
	} cdcs_drive_t;

	typedef enum logic [2:0] {
		PH_IDLE, PH_PRE, PH_FULL, PH_DIS, PH_NEXT, PH_WAIT
	} cdcs_phase_t;

endpackage

// *** design/cdcs_phase_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

// Down counter for one phase; load gives the cycle count, done stands while it is zero.
module cdcs_phase_timer
	import cdcs_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Control
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic [11:0] loadCount,
	// Status
	output logic             done
);
	logic [11:0] count_r;
	logic [11:0] count_nxt;

	assign count_nxt = load ? loadCount :
		((tick && count_r != 12'h000) ? count_r - 12'h001 : count_r);
	assign done = count_r == 12'h000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count_r <= 12'h000;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule

`default_nettype wire

// *** design/cdcs_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Full-charge code 1023 skips; else code+1 slow, code+2 fast cycles.
// - Discharge lasts code+1 slow or code+0 fast cycles, codes 0 to 1023.
// - Six port enable bits; the reference slot is always measured, then only enabled ports.
// - Reference bit picks external port 0/1 or internal port 6; internal not differential.
// - Sensor-type bit picks single-ended or differential port pairing.
// - Connection bit picks grounded or floating drive pattern.
// - Internal compensation bit widens the charge drive to the whole pair when set, unless floating high impedance masks it.
// - Parasitic compensation acts only with floating sensors, where high impedance or single-ended pairing leaves the charge drive unwidened.
// - Differential floating: balance bit puts one or both ports high impedance.
// - Conversion starts with 0 to 15 discarded dummy cycles.
// - Averaging sample size 0 to 8191, zero meaning a single sample.
// - Trigger source: continuous, read, timer, stretched, pin, command; 4 undefined.
// - Pin trigger selects one general-purpose input pin.
// - Timer period is twice the conversion time in slow-clock periods.
// - A conversion never ends before its dummy and averaged cycles are done.
// - Pre-charge 1023 skips; else code+1, or code+2 when fast and full skipped.
module cdcs_sequencer
	import cdcs_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	// Register port
	input  wire logic [3:0]           regAddr,
	input  wire logic [31:0]          regWrData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic [31:0]               regRdData,
	// Oscillator cycle ticks
	input  wire logic                 slowOscillatorTick,
	input  wire logic                 fastOscillatorTick,
	// Triggers
	input  wire logic [PIN_COUNT-1:0] gpioIn,
	input  wire logic                 resultRead,
	// Analog front end
	output cdcs_drive_t               portDrive,
	output logic                      sampleValid,
	output logic                      endOfConversion
);
	// ********************************************************************
	// Registers
	// ********************************************************************
	cdcs_timing_t tim_r;
	cdcs_seq_t    seq_r;
	logic [12:0]  avrg_r;
	logic [3:0]   fake_r;
	logic [2:0]   trig_r;
	logic [1:0]   pinSel_r;
	logic [23:0]  convTime_r;
	logic         cmdStart_r;
	logic         readStart_r;
	logic [31:0]  rdData_r;
	logic [15:0]  convCount_r;

	wire wrCharge = regWrite && regAddr == ADDR_CHARGE;
	wire wrDisch  = regWrite && regAddr == ADDR_DISCH;
	wire wrSeq    = regWrite && regAddr == ADDR_SEQ;
	wire wrConv   = regWrite && regAddr == ADDR_CONV;
	wire wrConvTm = regWrite && regAddr == ADDR_CONVTM;
	wire wrCmd    = regWrite && regAddr == ADDR_CMD;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tim_r      <= '{RST_PHASE, RST_PHASE, RST_PHASE, 1'b0};
			seq_r      <= '{RST_PORTEN, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
			avrg_r     <= RST_AVRG;
			fake_r     <= RST_FAKE;
			trig_r     <= RST_TRIG;
			pinSel_r   <= 2'h0;
			convTime_r <= RST_CONVTM;
		end else begin
			if (wrCharge) begin
				tim_r.preCharge  <= regWrData[9:0];
				tim_r.fullCharge <= regWrData[POS_FULL+:10];
			end
			if (wrDisch) begin
				tim_r.discharge <= regWrData[9:0];
			end
			if (wrSeq) begin
				seq_r.portEnable          <= regWrData[POS_PORTEN+:6];
				seq_r.refInternal         <= regWrData[POS_REFINT];
				seq_r.differential        <= regWrData[POS_DIFF];
				seq_r.floating            <= regWrData[POS_FLOAT];
				seq_r.compInternal        <= regWrData[POS_COMPINT];
				seq_r.parasiticCompEnable <= regWrData[POS_COMPEXT];
				seq_r.dcFreePortDrive     <= regWrData[POS_BALANCE];
				tim_r.fastOscillator      <= regWrData[POS_FASTOSC];
			end
			if (wrConv) begin
				avrg_r   <= regWrData[POS_AVRG+:13];
				fake_r   <= regWrData[POS_FAKE+:4];
				trig_r   <= regWrData[POS_TRIG+:3];
				pinSel_r <= regWrData[POS_PINSEL+:2];
			end
			if (wrConvTm) begin
				convTime_r <= regWrData[23:0];
			end
		end
	end

	// ********************************************************************
	// Trigger selection
	// ********************************************************************
	cdcs_phase_t state_r;
	logic [1:0]  pinHist_r;
	logic [24:0] timer_r;
	logic        timerHit;
	logic        pendingTimer_r;
	wire         idle      = state_r == PH_IDLE;
	wire [24:0]  timerLoad = {convTime_r, 1'b0};
	wire         pinLevel  = gpioIn[pinSel_r];
	wire         pinRise   = pinHist_r == 2'b01;
	wire         isTimer   = trig_r == TRIG_TIMER || trig_r == TRIG_STRETCH;

	assign timerHit = isTimer && slowOscillatorTick && timer_r <= 25'h0000001;

	// Stretched mode holds a missed tick until the sequencer is free.
	logic startReq;
	always_comb begin
		case (trig_r)
			TRIG_CONT, TRIG_CONTEXP: startReq = 1'b1;
			TRIG_READ:               startReq = readStart_r;
			TRIG_TIMER:              startReq = timerHit;
			TRIG_STRETCH:            startReq = timerHit || pendingTimer_r;
			TRIG_PIN:                startReq = pinRise;
			TRIG_CMD:                startReq = cmdStart_r;
			default:                 startReq = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pinHist_r      <= 2'b00;
			timer_r        <= 25'h0000000;
			pendingTimer_r <= 1'b0;
			cmdStart_r     <= 1'b0;
			readStart_r    <= 1'b0;
		end else begin
			pinHist_r <= {pinHist_r[0], pinLevel};
			if (!isTimer || timerHit) begin
				timer_r <= timerLoad;
			end else if (slowOscillatorTick) begin
				timer_r <= timer_r - 25'h0000001;
			end
			pendingTimer_r <= trig_r == TRIG_STRETCH && !idle && (timerHit || pendingTimer_r);
			cmdStart_r  <= (wrCmd && regWrData[0]) || (cmdStart_r && !idle);
			readStart_r <= resultRead || (readStart_r && !idle);
		end
	end

	// ********************************************************************
	// Port sequence
	// ********************************************************************
	// Slot list: ref, then enabled ports.
	logic [2:0]  slot_r;
	logic [3:0]  fakeLeft_r;
	logic [12:0] avrgLeft_r;
	wire         tick = tim_r.fastOscillator ? fastOscillatorTick : slowOscillatorTick;
	wire         useInt = seq_r.refInternal && !seq_r.differential;
	wire [2:0]   portStep = seq_r.differential ? 3'h2 : 3'h1;
	wire         compOk = seq_r.compInternal;
	wire         parOk  = seq_r.parasiticCompEnable && seq_r.floating;

	// Next enabled port after the current slot, or 7 if none remain.
	logic [2:0] nextPort;
	always_comb begin
		nextPort = 3'h7;
		for (int i = PORT_COUNT - 1; i >= 0; i--) begin
			if (seq_r.portEnable[i] && 3'(i) > slot_r && (3'(i) % portStep) == 3'h0) begin
				nextPort = 3'(i);
			end
		end
	end

	// ********************************************************************
	// Phase lengths
	// ********************************************************************
	wire skipPre  = tim_r.preCharge == PHASE_SKIP;
	wire skipFull = tim_r.fullCharge == PHASE_SKIP;
	wire [11:0] preLen = {2'b00, tim_r.preCharge} +
		((tim_r.fastOscillator && skipFull) ? 12'h002 : 12'h001);
	wire [11:0] fullLen = {2'b00, tim_r.fullCharge} +
		(tim_r.fastOscillator ? 12'h002 : 12'h001);
	wire [11:0] disLen = {2'b00, tim_r.discharge} +
		(tim_r.fastOscillator ? 12'h000 : 12'h001);

	logic        ldTimer;
	logic [11:0] ldCount;
	logic        phaseDone;

	cdcs_phase_timer uPhase (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.tick      (tick),
		.load      (ldTimer),
		.loadCount (ldCount),
		.done      (phaseDone)
	);

	// ********************************************************************
	// Sequencer
	// ********************************************************************
	cdcs_phase_t state_nxt;
	logic        slotEnd;
	logic        lastSlot;
	logic        eocPulse_r;
	logic        valid_r;

	assign lastSlot = nextPort == 3'h7;
	always_comb begin
		state_nxt = state_r;
		ldTimer   = 1'b0;
		ldCount   = 12'h000;
		slotEnd   = 1'b0;
		case (state_r)
			PH_IDLE: begin
				if (startReq) begin
					state_nxt = PH_PRE;
				end
			end
			PH_PRE: begin
				ldTimer   = 1'b1;
				ldCount   = skipPre ? 12'h000 : preLen;
				state_nxt = PH_FULL;
			end
			PH_FULL: begin
				if (phaseDone) begin
					ldTimer   = 1'b1;
					ldCount   = skipFull ? 12'h000 : fullLen;
					state_nxt = PH_DIS;
				end
			end
			PH_DIS: begin
				if (phaseDone) begin
					ldTimer   = 1'b1;
					ldCount   = disLen;
					state_nxt = PH_WAIT;
				end
			end
			PH_WAIT: begin
				if (phaseDone) begin
					state_nxt = PH_NEXT;
				end
			end
			PH_NEXT: begin
				slotEnd   = 1'b1;
				state_nxt = PH_PRE;
				if (lastSlot && fakeLeft_r == 4'h0 && avrgLeft_r <= 13'h0001) begin
					state_nxt = PH_IDLE;
				end
			end
			default: state_nxt = PH_IDLE;
		endcase
	end

	wire seqEnd = slotEnd && lastSlot;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r     <= PH_IDLE;
			slot_r      <= 3'h0;
			fakeLeft_r  <= 4'h0;
			avrgLeft_r  <= 13'h0000;
			eocPulse_r  <= 1'b0;
			valid_r     <= 1'b0;
			convCount_r <= 16'h0000;
		end else begin
			state_r    <= state_nxt;
			eocPulse_r <= slotEnd && state_nxt == PH_IDLE;
			valid_r    <= seqEnd && fakeLeft_r == 4'h0;
			if (idle && startReq) begin
				slot_r     <= 3'h0;
				fakeLeft_r <= fake_r;
				avrgLeft_r <= avrg_r;
			end else if (slotEnd) begin
				slot_r <= lastSlot ? 3'h0 : nextPort;
				if (seqEnd && fakeLeft_r != 4'h0) begin
					fakeLeft_r <= fakeLeft_r - 4'h1;
				end else if (seqEnd && avrgLeft_r != 13'h0000) begin
					avrgLeft_r <= avrgLeft_r - 13'h0001;
				end
			end
			if (eocPulse_r) begin
				convCount_r <= convCount_r + 16'h0001;
			end
		end
	end

	assign endOfConversion = eocPulse_r;
	assign sampleValid     = valid_r;

	// ********************************************************************
	// Port drive pattern
	// ********************************************************************
	wire        charging = state_r == PH_FULL || state_r == PH_DIS;
	wire [6:0]  refMask  = useInt ? 7'h40 : (seq_r.floating ? 7'h03 : 7'h01);
	wire [6:0]  curMask  = (slot_r == 3'h0) ? refMask : 7'(7'h01 << slot_r);
	// Both ports of a differential pair are sensed at once, so they see one sample.
	wire [6:0]  pairMask = seq_r.differential ? (curMask | (curMask << 1)) : curMask;
	wire        diffFlt  = seq_r.differential && seq_r.floating;
	wire [6:0]  hzMask   = diffFlt ?
		(seq_r.dcFreePortDrive ? pairMask : (curMask << 1)) : 7'h00;
	wire [6:0]  compMask = (compOk || parOk) ? pairMask : curMask;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			portDrive <= '{7'h00, 7'h00, 7'h00};
		end else begin
			portDrive.charge <= charging ? (compMask & ~hzMask) : 7'h00;
			portDrive.highZ  <= idle ? 7'h00 : hzMask;
			portDrive.sense  <= idle ? 7'h00 : pairMask;
		end
	end

	// ********************************************************************
	// Read data
	// ********************************************************************
	wire [31:0] rdMux =
		(regAddr == ADDR_CHARGE) ? {6'h00, tim_r.fullCharge, 6'h00, tim_r.preCharge} :
		(regAddr == ADDR_DISCH)  ? {22'h000000, tim_r.discharge} :
		(regAddr == ADDR_SEQ)    ? {17'h00000, tim_r.fastOscillator, seq_r.dcFreePortDrive,
			seq_r.parasiticCompEnable, seq_r.compInternal, seq_r.floating,
			seq_r.differential, seq_r.refInternal, 2'h0, seq_r.portEnable} :
		(regAddr == ADDR_CONV)   ? {6'h00, pinSel_r, 1'b0, trig_r, fake_r, 3'h0, avrg_r} :
		(regAddr == ADDR_CONVTM) ? {8'h00, convTime_r} :
		(regAddr == ADDR_STATUS) ? {25'h0000000, avrgLeft_r == 13'h0000, fakeLeft_r != 4'h0,
			slot_r, idle, 1'b0} :
		(regAddr == ADDR_COUNT)  ? {16'h0000, convCount_r} : 32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdData_r <= 32'h00000000;
		end else begin
			rdData_r <= regRead ? rdMux : 32'h00000000;
		end
	end
	assign regRdData = rdData_r;

	// ********************************************************************
	// Checks
	// ********************************************************************
	eoc_one_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)
		endOfConversion |=> !endOfConversion) else $error("end of conversion too long");
	eoc_goes_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		endOfConversion |-> state_r == PH_IDLE) else $error("end without idle");
	int_ref_diff_a: assert property (@(posedge ref_clk) disable iff (reset)
		seq_r.differential |=> !portDrive.sense[6]) else $error("internal ref with differential");
	pre_length_a: assert property (@(posedge ref_clk) disable iff (reset)
		(state_r == PH_PRE && !skipPre && tim_r.fastOscillator && skipFull)
		|=> uPhase.count_r == 12'({2'b00, $past(tim_r.preCharge)} + 12'h002))
		else $error("pre-charge length wrong");
	full_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
		(state_r == PH_FULL && phaseDone && skipFull) |=> phaseDone)
		else $error("skipped full-charge not skipped");
	dis_length_a: assert property (@(posedge ref_clk) disable iff (reset)
		(state_r == PH_DIS && phaseDone && !tim_r.fastOscillator)
		|=> uPhase.count_r == 12'({2'b00, $past(tim_r.discharge)} + 12'h001))
		else $error("discharge length wrong");
	trig_undef_a: assert property (@(posedge ref_clk) disable iff (reset)
		(idle && trig_r == 3'h4) |=> idle) else $error("undefined trigger started");
	dummy_no_valid_a: assert property (@(posedge ref_clk) disable iff (reset)
		(seqEnd && fakeLeft_r != 4'h0) |=> !sampleValid) else $error("dummy result kept");
	timer_load_a: assert property (@(posedge ref_clk) disable iff (reset)
		(timerHit && trig_r == TRIG_TIMER) |=> timer_r == $past(timerLoad))
		else $error("timer period wrong");
endmodule

`default_nettype wire

// *** bench/cdcs_sensor_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ********************************************************************
// Sensor side model
// ********************************************************************
module cdcs_sensor_model
	import cdcs_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Slow oscillator period in ref_clk cycles, 1 ticks every cycle
	input  wire logic [3:0]  slowPeriod,
	// Front end
	input  wire cdcs_drive_t portDrive,
	input  wire logic        sampleValid,
	input  wire logic        clearSeen,
	output logic             slowOscillatorTick,
	output logic             fastOscillatorTick,
	output logic [6:0]       senseSeen,
	output logic [6:0]       chargeSeen,
	output logic [6:0]       hzSeen,
	output logic [15:0]      sampleCount
);
	logic [3:0] slowCnt_r;

	// The fast oscillator ticks every cycle, so fast phase lengths read directly in cycles.
	assign fastOscillatorTick = !reset;
	assign slowOscillatorTick = !reset && (slowCnt_r == 4'h0);

	always_ff @(posedge ref_clk) begin
		if (reset || slowCnt_r + 4'h1 >= slowPeriod) begin
			slowCnt_r <= 4'h0;
		end else begin
			slowCnt_r <= slowCnt_r + 4'h1;
		end
		if (reset || clearSeen) begin
			senseSeen   <= 7'h00;
			chargeSeen  <= 7'h00;
			hzSeen      <= 7'h00;
			sampleCount <= 16'h0000;
		end else begin
			senseSeen   <= senseSeen | portDrive.sense;
			chargeSeen  <= chargeSeen | portDrive.charge;
			hzSeen      <= hzSeen | portDrive.highZ;
			sampleCount <= sampleCount + {15'h0000, sampleValid};
		end
	end
endmodule

`default_nettype wire

// *** bench/cdcs_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module cdcs_sequencer_tb
	import cdcs_pkg::*;
;
	logic                 ref_clk = 1'b0;
	logic                 reset   = 1'b1;
	logic [3:0]           regAddr = 4'h0;
	logic [31:0]          regWrData = 32'h0;
	logic                 regWrite = 1'b0;
	logic                 regRead = 1'b0;
	logic [31:0]          regRdData;
	logic                 slowTick;
	logic                 fastTick;
	logic [PIN_COUNT-1:0] gpioIn = '0;
	logic                 resultRead = 1'b0;
	cdcs_drive_t          portDrive;
	logic                 sampleValid;
	logic                 endOfConversion;
	logic [3:0]           slowPeriod = 4'h1;
	logic                 clearSeen = 1'b0;
	logic [6:0]           senseSeen;
	logic [6:0]           chargeSeen;
	logic [6:0]           hzSeen;
	logic [15:0]          sampleCount;
	int                   n_fail = 0;
	int                   n_compared = 0;
	// Columns: pre, full, discharge, fast, dummy count, averaging.
	int cases [13][6] = '{'{0, 0, 0, 0, 0, 0}, '{0, 3, 0, 0, 0, 0}, '{0, 1023, 0, 0, 0, 0},
		'{0, 1022, 0, 0, 0, 0}, '{0, 3, 0, 1, 0, 0}, '{0, 1023, 0, 1, 0, 0},
		'{5, 0, 7, 0, 0, 0}, '{5, 0, 7, 1, 0, 0}, '{1023, 1023, 0, 1, 0, 0},
		'{0, 0, 0, 0, 3, 0}, '{0, 0, 0, 0, 15, 0}, '{0, 0, 0, 0, 0, 1}, '{0, 0, 0, 0, 2, 8}};

	always #10 ref_clk = !ref_clk;

	cdcs_sequencer uut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.slowOscillatorTick(slowTick), .fastOscillatorTick(fastTick), .gpioIn(gpioIn),
		.resultRead(resultRead), .portDrive(portDrive), .sampleValid(sampleValid),
		.endOfConversion(endOfConversion));

	cdcs_sensor_model sensors (.ref_clk(ref_clk), .reset(reset), .slowPeriod(slowPeriod),
		.portDrive(portDrive), .sampleValid(sampleValid), .clearSeen(clearSeen),
		.slowOscillatorTick(slowTick), .fastOscillatorTick(fastTick),
		.senseSeen(senseSeen), .chargeSeen(chargeSeen), .hzSeen(hzSeen),
		.sampleCount(sampleCount));

	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	task automatic results;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A gap cycle after each strobe keeps every signal to one assignment per time step.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		d = regRdData;
		@(posedge ref_clk);
	endtask

	task automatic waitEoc(input int bound, input bit mustSee, output int cyc);
		for (cyc = 1; cyc <= bound; cyc++) begin
			@(negedge ref_clk);
			if (endOfConversion === 1'b1) begin
				break;
			end
		end
		@(posedge ref_clk);
		if (mustSee && cyc > bound) begin
			check("conversion end in time", 32'h0, 32'h1);
			results();
		end
	endtask

	task automatic idleWait;
		logic [31:0] d;
		for (int i = 0; i < 200; i++) begin
			rd(ADDR_STATUS, d);
			if (d[1] === 1'b1) begin
				return;
			end
		end
		check("idle in time", 32'h0, 32'h1);
		results();
	endtask

	task automatic run(output int cyc);
		clearSeen <= 1'b1;
		@(posedge ref_clk);
		clearSeen <= 1'b0;
		wr(ADDR_CMD, 32'h00000001);
		waitEoc(30000, 1'b1, cyc);
		idleWait();
	endtask

	function automatic int perSlot(input int pr, input int fu, input int di, input int fa);
		int f;
		int p;
		f = (fu == 1023) ? 0 : fu + (fa ? 2 : 1);
		p = (pr == 1023) ? 0 : pr + ((fa && fu == 1023) ? 2 : 1);
		return 5 + p + f + di + (fa ? 0 : 1);
	endfunction

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic test_reset;
		logic [31:0] d;
		logic [31:0] exp;
		@(negedge ref_clk);
		check("idle outputs", {9'h0, portDrive, sampleValid, endOfConversion}, 32'h0);
		@(posedge ref_clk);
		wr(4'h9, 32'hFFFFFFFF);
		wr(ADDR_STATUS, 32'hFFFFFFFF);
		wr(ADDR_COUNT, 32'hFFFFFFFF);
		for (int a = 0; a < 16; a++) begin
			exp = (a == 3) ? 32'h00600000 : (a == 6) ? 32'h00000042 : 32'h0;
			if (a != 5) begin
				rd(4'(a), d);
				check("reset value", d, exp);
			end
		end
		#1;
		check("read data outside read", regRdData, 32'h0);
		@(posedge ref_clk);
		$display("test_reset done");
	endtask

	task automatic test_timing;
		int t0;
		int t;
		int seqs;
		logic [31:0] d;
		for (int i = 0; i < 13; i++) begin
			wr(ADDR_CHARGE, 32'(cases[i][1]) << POS_FULL | 32'(cases[i][0]));
			wr(ADDR_DISCH, 32'(cases[i][2]));
			wr(ADDR_SEQ, 32'h00000104 | 32'(cases[i][3]) << POS_FASTOSC);
			wr(ADDR_CONV, 32'(cases[i][5]) | 32'(cases[i][4]) << POS_FAKE | 32'(TRIG_CMD) << POS_TRIG);
			run(t);
			seqs = cases[i][4] + (cases[i][5] > 0 ? cases[i][5] : 1);
			if (i == 0) begin
				t0 = t;
			end
			check("conversion length", 32'(t - t0), 32'(2 * (seqs * perSlot(cases[i][0],
				cases[i][1], cases[i][2], cases[i][3]) - perSlot(0, 0, 0, 0))));
			check("samples", {16'h0, sampleCount}, 32'(seqs - cases[i][4]));
			check("sense ports", {25'h0, senseSeen}, 32'h00000044);
		end
		rd(ADDR_COUNT, d);
		check("conversion count", d, 32'h0000000D);
		$display("test_timing done");
	endtask

	task automatic test_pairing;
		int t;
		wr(ADDR_CHARGE, 32'h0);
		wr(ADDR_CONV, 32'(TRIG_CMD) << POS_TRIG);
		wr(ADDR_SEQ, 32'h00000304);
		run(t);
		check("differential pair", {25'h0, senseSeen}, 32'h0000000F);
		wr(ADDR_SEQ, 32'h00000004);
		run(t);
		check("external reference", {25'h0, senseSeen & 7'h7C}, 32'h00000004);
		$display("test_pairing done");
	endtask

	task automatic test_drive;
		int t;
		wr(ADDR_SEQ, 32'h00000A04);
		run(t);
		check("compensated pair charge", {25'h0, chargeSeen}, 32'h0000000F);
		wr(ADDR_SEQ, 32'h00001204);
		run(t);
		check("parasitic when grounded", {25'h0, chargeSeen}, 32'h00000005);
		wr(ADDR_SEQ, 32'h00000604);
		run(t);
		check("single high impedance", {25'h0, hzSeen}, 32'h0000000E);
		wr(ADDR_SEQ, 32'h00002604);
		run(t);
		check("dc-free high impedance", {25'h0, hzSeen}, 32'h0000000F);
		check("dc-free charge", {25'h0, chargeSeen}, 32'h00000000);
		wr(ADDR_SEQ, 32'h00000404);
		run(t);
		check("floating reference", {25'h0, senseSeen}, 32'h00000007);
		$display("test_drive done");
	endtask

	task automatic test_trigger;
		logic [2:0] modes [4] = '{TRIG_CONT, TRIG_CONTEXP, TRIG_TIMER, TRIG_STRETCH};
		int cyc;
		wr(ADDR_CONVTM, 32'h00000014);
		for (int m = 0; m < 5; m++) begin
			slowPeriod <= (m == 4) ? 4'h2 : 4'h1;
			wr(ADDR_CONV, 32'(modes[(m == 4) ? 2 : m]) << POS_TRIG);
			waitEoc(2000, 1'b1, cyc);
			waitEoc(2000, 1'b1, cyc);
			if (m >= 2) begin
				check("timer period", 32'(cyc), (m == 4) ? 32'h00000050 : 32'h00000028);
			end
			wr(ADDR_CONV, 32'(TRIG_CMD) << POS_TRIG);
			idleWait();
		end
		wr(ADDR_CONV, 32'h4 << POS_TRIG);
		waitEoc(400, 1'b0, cyc);
		check("undefined trigger", 32'(cyc > 400), 32'h1);
		wr(ADDR_CONV, 32'(TRIG_READ) << POS_TRIG);
		waitEoc(200, 1'b0, cyc);
		check("read trigger idle", 32'(cyc > 200), 32'h1);
		resultRead <= 1'b1;
		@(posedge ref_clk);
		resultRead <= 1'b0;
		waitEoc(2000, 1'b1, cyc);
		wr(ADDR_CONV, 32'(TRIG_PIN) << POS_TRIG | 32'h2 << POS_PINSEL);
		gpioIn <= 4'h2;
		waitEoc(200, 1'b0, cyc);
		check("other pin ignored", 32'(cyc > 200), 32'h1);
		gpioIn <= 4'h6;
		waitEoc(2000, 1'b1, cyc);
		gpioIn <= 4'h0;
		wr(ADDR_CONV, 32'(TRIG_CMD) << POS_TRIG);
		idleWait();
		$display("test_trigger done");
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		test_reset();
		test_timing();
		test_pairing();
		test_drive();
		test_trigger();
		results();
	end
endmodule

`default_nettype wire
